//--- common/dds_consts.svh
// Constants for the serial waveform generator: word fields, control bits, timing counts.
// Assumes inclusion by bare name from files that also import dds_pkg.
`ifndef DDS_CONSTS_SVH
`define DDS_CONSTS_SVH

// ==========================================================================
// Serial word layout
// ==========================================================================
`define DDS_WORD_BITS     16
`define DDS_ADDR_HI       15
`define DDS_ADDR_LO       14
`define DDS_ADDR_CTRL     2'h0
`define DDS_ADDR_FREQ_A   2'h1
`define DDS_ADDR_FREQ_B   2'h2
`define DDS_ADDR_PHASE    2'h3
`define DDS_PAYLOAD_HI    13
`define DDS_PHASE_SEL     13
`define DDS_PHASE_HI      11

// ==========================================================================
// Control word bit positions
// ==========================================================================
`define DDS_B_FULL_WIDTH  13
`define DDS_B_HALF_SEL    12
`define DDS_B_FREQ_BANK   11
`define DDS_B_PHASE_BANK  10
`define DDS_B_ACC_RESET   8
`define DDS_B_CLK_GATE    7
`define DDS_B_DAC_OFF     6
`define DDS_B_SQUARE_EN   5
`define DDS_B_NO_HALVE    3
`define DDS_B_MODE        1

// ==========================================================================
// Reset values and timing
// ==========================================================================
`define DDS_MIDSCALE      10'h200
`define DDS_START_CYCLES  4'h8
`define DDS_SCLK_HALF     3'h3
`define DDS_BIT_LAST      4'hF
`define DDS_INIT_WORD     16'h0100

`endif

//--- common/dds_link_if.sv
// Three-wire serial link between the host and the waveform generator.
// Assumes one common clock; the host drives every wire.
`timescale 1ns/1ps

interface dds_link_if;
  logic sclk;
  logic frame_sync_n;
  logic serial_in;

  modport host   (output sclk, output frame_sync_n, output serial_in);
  modport device (input sclk, input frame_sync_n, input serial_in);
endinterface

//--- common/dds_pkg.sv
// Types shared by both ends of the serial waveform generator link.
// Assumes nothing beyond a SystemVerilog compiler.
package dds_pkg;

  // ========================================================================
  // Types
  // ========================================================================
  typedef logic [15:0] dds_word_type;
  typedef logic [27:0] dds_freq_type;
  typedef logic [11:0] dds_phase_type;

  typedef enum logic [2:0] {
    DDS_RX_IDLE  = 3'b001,
    DDS_RX_SHIFT = 3'b010,
    DDS_RX_WAIT  = 3'b100
  } dds_rx_state_type;

  typedef enum logic [4:0] {
    DDS_TX_IDLE  = 5'b00001,
    DDS_TX_SETUP = 5'b00010,
    DDS_TX_LOW   = 5'b00100,
    DDS_TX_HIGH  = 5'b01000,
    DDS_TX_END   = 5'b10000
  } dds_tx_state_type;

endpackage

//--- design/dds_device.sv
// Waveform generator end: serial word decoder, frequency and phase banks, accumulator,
// output select. Assumes sclk, frame_sync_n and serial_in are synchronous to core_clk.
// Function
// - Top bits 00 mean a control word.
// - Top bits 01/10 write frequency word A/B.
// - Full-width mode: low half then high half.
// - Half mode: one write changes one half.
// - Half-select picks low or high half.
// - Top bits 11 load phase offset A/B.
// - Reset bit clears accumulator, keeps registers.
// - Output resumes eight cycles after reset clears.
// - Host resets after power-up; a later user control word clears.
// - Two sleep bits decode four power states.
// - Clock gated: accumulator and output hold.
// - Writes still accepted while clock gated.
// - Sine path when square off, mode 0.
// - Mode 1 bypasses sine: 9-bit triangle, LSB zero.
// - Square output is MSB, optionally halved.
// - Host keeps converter on for triangle.
// - Bank pick chooses driving frequency word.
// - Output frequency is clock times word/2^28.
// - Selected phase offset added before conversion.
// - Frame sync low frames 16 bits.
`timescale 1ns/1ps
`include "dds_consts.svh"

module dds_device
  import dds_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Serial link from the host
  dds_link_if.device      link,
  // Converter side
  output logic      [9:0] dac_code,
  output logic            dac_powered,
  output logic            square_out,
  // Status
  output logic            core_running
);

  // ========================================================================
  // Serial receiver
  // ========================================================================
  dds_rx_state_type rx_state;
  dds_rx_state_type next_rx_state;
  logic [14:0]      shift;
  logic [14:0]      next_shift;
  logic [3:0]       bit_count;
  logic [3:0]       next_bit_count;
  logic             sclk_q;
  logic             word_strobe;
  logic             next_word_strobe;
  dds_word_type     rx_word;
  dds_word_type     next_rx_word;
  logic             sclk_fall;

  assign sclk_fall = sclk_q & ~link.sclk;

  // Bits are taken on falling serial-clock edges while the frame is low.
  // A frame that ends early drops the partial word instead of decoding it.
  always_comb
  begin
    next_rx_state    = rx_state;
    next_shift       = shift;
    next_bit_count   = bit_count;
    next_word_strobe = 1'b0;
    next_rx_word     = rx_word;
    unique case (rx_state)
      DDS_RX_IDLE:
        if (!link.frame_sync_n)
        begin
          next_rx_state  = DDS_RX_SHIFT;
          next_bit_count = 4'h0;
        end
      DDS_RX_SHIFT:
        if (link.frame_sync_n)
          next_rx_state = DDS_RX_IDLE;
        else if (sclk_fall)
        begin
          next_shift     = {shift[13:0], link.serial_in};
          next_bit_count = bit_count + 4'h1;
          if (bit_count == `DDS_BIT_LAST)
          begin
            next_rx_word     = {shift, link.serial_in};
            next_word_strobe = 1'b1;
            next_rx_state    = DDS_RX_WAIT;
          end
        end
      DDS_RX_WAIT:
        if (link.frame_sync_n)
          next_rx_state = DDS_RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_state    <= DDS_RX_IDLE;
      shift       <= 15'h0000;
      bit_count   <= 4'h0;
      sclk_q      <= 1'b1;
      word_strobe <= 1'b0;
      rx_word     <= 16'h0000;
    end
    else
    begin
      rx_state    <= next_rx_state;
      shift       <= next_shift;
      bit_count   <= next_bit_count;
      sclk_q      <= link.sclk;
      word_strobe <= next_word_strobe;
      rx_word     <= next_rx_word;
    end
  end

  // ========================================================================
  // Word decoder and register banks
  // ========================================================================
  dds_freq_type  freq_word_a;
  dds_freq_type  freq_word_b;
  dds_phase_type phase_offset_a;
  dds_phase_type phase_offset_b;
  dds_freq_type  next_freq_a;
  dds_freq_type  next_freq_b;
  dds_phase_type next_phase_a;
  dds_phase_type next_phase_b;
  logic [15:0]   control;
  logic [15:0]   next_control;
  logic [13:0]   low_stage;
  logic [13:0]   next_low_stage;
  logic          stage_pending;
  logic          next_stage_pending;
  logic [1:0]    stage_addr;
  logic [1:0]    next_stage_addr;
  logic [1:0]    addr;
  logic [13:0]   payload;
  logic          commit;

  assign addr    = rx_word[`DDS_ADDR_HI:`DDS_ADDR_LO];
  assign payload = rx_word[`DDS_PAYLOAD_HI:0];
  assign commit  = stage_pending && (stage_addr == addr);

  // New value of one frequency word for a write of either bank.
  function automatic dds_freq_type dds_freq_update(input dds_freq_type old,
                                                   input logic [13:0] pay,
                                                   input logic full,
                                                   input logic done,
                                                   input logic [13:0] low,
                                                   input logic high_half);
    if (full)
      dds_freq_update = done ? {pay, low} : old;
    else if (high_half)
      dds_freq_update = {pay, old[13:0]};
    else
      dds_freq_update = {old[27:14], pay};
  endfunction

  // Writes are honoured in every power state, including a gated clock.
  always_comb
  begin
    next_freq_a        = freq_word_a;
    next_freq_b        = freq_word_b;
    next_phase_a       = phase_offset_a;
    next_phase_b       = phase_offset_b;
    next_control       = control;
    next_low_stage     = low_stage;
    next_stage_pending = stage_pending;
    next_stage_addr    = stage_addr;
    if (word_strobe)
    begin
      unique case (addr)
        `DDS_ADDR_CTRL:
        begin
          next_control       = rx_word;
          next_stage_pending = 1'b0;
        end
        `DDS_ADDR_FREQ_A, `DDS_ADDR_FREQ_B:
        begin
          if (addr == `DDS_ADDR_FREQ_A)
            next_freq_a = dds_freq_update(freq_word_a, payload,
                            control[`DDS_B_FULL_WIDTH], commit, low_stage,
                            control[`DDS_B_HALF_SEL]);
          else
            next_freq_b = dds_freq_update(freq_word_b, payload,
                            control[`DDS_B_FULL_WIDTH], commit, low_stage,
                            control[`DDS_B_HALF_SEL]);
          // A first write of a pair is staged; a write to the other frequency word restarts it.
          next_stage_pending = control[`DDS_B_FULL_WIDTH] && !commit;
          next_low_stage     = payload;
          next_stage_addr    = addr;
        end
        `DDS_ADDR_PHASE:
          if (rx_word[`DDS_PHASE_SEL])
            next_phase_b = rx_word[`DDS_PHASE_HI:0];
          else
            next_phase_a = rx_word[`DDS_PHASE_HI:0];
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      freq_word_a    <= 28'h0000000;
      freq_word_b    <= 28'h0000000;
      phase_offset_a <= 12'h000;
      phase_offset_b <= 12'h000;
      control        <= 16'h0000;
      low_stage      <= 14'h0000;
      stage_pending  <= 1'b0;
      stage_addr     <= 2'h0;
    end
    else
    begin
      freq_word_a    <= next_freq_a;
      freq_word_b    <= next_freq_b;
      phase_offset_a <= next_phase_a;
      phase_offset_b <= next_phase_b;
      control        <= next_control;
      low_stage      <= next_low_stage;
      stage_pending  <= next_stage_pending;
      stage_addr     <= next_stage_addr;
    end
  end

  // ========================================================================
  // Accumulator and output select
  // ========================================================================
  logic [27:0]   acc;
  logic [27:0]   next_acc;
  logic [3:0]    start_cnt;
  logic [3:0]    next_start_cnt;
  logic          msb_q;
  logic          halve_tog;
  logic          next_halve_tog;
  logic [9:0]    next_dac_code;
  logic          next_square_out;
  logic          run;
  logic          gated;
  logic          acc_reset;
  dds_freq_type  freq_sel;
  dds_phase_type phase_sum;
  logic [9:0]    phase10;
  logic [8:0]    tri_half;
  logic [9:0]    sine_amp;

  assign acc_reset = control[`DDS_B_ACC_RESET];
  assign gated     = control[`DDS_B_CLK_GATE];
  assign run       = !gated && !acc_reset && (start_cnt == 4'h0);
  assign freq_sel  = control[`DDS_B_FREQ_BANK] ? freq_word_b : freq_word_a;
  assign phase_sum = acc[27:16] + (control[`DDS_B_PHASE_BANK] ?
                                   phase_offset_b : phase_offset_a);
  assign phase10   = phase_sum[11:2];
  assign tri_half  = phase10[9] ? ~phase10[8:0] : phase10[8:0];

  dds_sine_lookup u_sine_lookup
  (
    .phase     (phase10),
    .amplitude (sine_amp)
  );

  // The accumulator and output stage advance only on enabled cycles.
  always_comb
  begin
    next_acc        = acc;
    next_start_cnt  = start_cnt;
    next_dac_code   = dac_code;
    next_square_out = square_out;
    next_halve_tog  = halve_tog;
    if (acc_reset)
    begin
      next_acc        = 28'h0000000;
      next_start_cnt  = `DDS_START_CYCLES;
      next_dac_code   = `DDS_MIDSCALE;
      next_square_out = 1'b0;
      next_halve_tog  = 1'b0;
    end
    else if (gated)
    begin
      // Everything holds; the last code stays on the converter.
    end
    else if (start_cnt != 4'h0)
      next_start_cnt = start_cnt - 4'h1;
    else
    begin
      next_acc = acc + freq_sel;
      if (phase10[9] && !msb_q)
        next_halve_tog = ~halve_tog;
      unique case ({control[`DDS_B_SQUARE_EN], control[`DDS_B_MODE]})
        2'h0: next_dac_code = sine_amp;
        2'h1: next_dac_code = {tri_half, 1'b0};
        2'h2: next_square_out = control[`DDS_B_NO_HALVE] ?
                                phase10[9] : halve_tog;
        2'h3:
        begin
          next_dac_code   = `DDS_MIDSCALE;
          next_square_out = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc          <= 28'h0000000;
      start_cnt    <= 4'h0;
      msb_q        <= 1'b0;
      halve_tog    <= 1'b0;
      dac_code     <= `DDS_MIDSCALE;
      square_out   <= 1'b0;
      dac_powered  <= 1'b1;
      core_running <= 1'b0;
    end
    else
    begin
      acc          <= next_acc;
      start_cnt    <= next_start_cnt;
      msb_q        <= run ? phase10[9] : msb_q;
      halve_tog    <= next_halve_tog;
      dac_code     <= next_dac_code;
      square_out   <= next_square_out;
      dac_powered  <= !control[`DDS_B_DAC_OFF];
      core_running <= run;
    end
  end

endmodule // dds_device

//--- design/dds_host.sv
// Host end: sends 16-bit words over the three-wire link, MSB first.
// Assumes the user holds cmd_word steady while cmd_valid is high.
`timescale 1ns/1ps
`include "dds_consts.svh"

module dds_host
  import dds_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  // User command port
  input  wire logic         cmd_valid,
  input  wire dds_word_type cmd_word,
  output logic              cmd_ready,
  // Serial link to the device
  dds_link_if.host          link
);

  // ========================================================================
  // Transmit state
  // ========================================================================
  dds_tx_state_type state;
  dds_tx_state_type next_state;
  dds_word_type     shift;
  dds_word_type     next_shift;
  dds_word_type     user_word;
  logic [2:0]       div;
  logic [2:0]       next_div;
  logic [3:0]       bits;
  logic [3:0]       next_bits;
  logic             init_done;
  logic             next_init_done;
  logic             next_ready;
  logic             next_sclk;
  logic             next_fs_n;
  logic             next_serial_in;
  logic             sclk_r;
  logic             fs_n_r;
  logic             serial_in_r;

  assign link.sclk         = sclk_r;
  assign link.frame_sync_n = fs_n_r;
  assign link.serial_in    = serial_in_r;

  // Converter-off is dropped from any control word that selects the triangle.
  always_comb
  begin
    user_word = cmd_word;
    if (cmd_word[`DDS_ADDR_HI:`DDS_ADDR_LO] == `DDS_ADDR_CTRL && cmd_word[`DDS_B_MODE])
      user_word[`DDS_B_DAC_OFF] = 1'b0;
  end

  // Data changes with the rising serial edge so it is stable at the falling one.
  always_comb
  begin
    next_state     = state;
    next_shift     = shift;
    next_div       = (div == 3'h0) ? `DDS_SCLK_HALF - 3'h1 : div - 3'h1;
    next_bits      = bits;
    next_init_done = init_done;
    next_ready     = cmd_ready;
    next_sclk      = sclk_r;
    next_fs_n      = fs_n_r;
    next_serial_in     = serial_in_r;
    unique case (state)
      DDS_TX_IDLE:
        if (!init_done || (cmd_valid && cmd_ready))
        begin
          // The first word after reset holds the accumulator in reset.
          next_shift     = init_done ? user_word : `DDS_INIT_WORD;
          next_serial_in     = init_done ? user_word[15] : 1'(`DDS_INIT_WORD >> 15);
          next_init_done = 1'b1;
          next_ready     = 1'b0;
          next_fs_n      = 1'b0;
          next_bits      = 4'h0;
          next_div       = `DDS_SCLK_HALF - 3'h1;
          next_state     = DDS_TX_SETUP;
        end
      DDS_TX_SETUP, DDS_TX_HIGH:
        if (div == 3'h0)
        begin
          next_sclk  = 1'b0;
          next_state = DDS_TX_LOW;
        end
      DDS_TX_LOW:
        if (div == 3'h0)
        begin
          next_sclk = 1'b1;
          next_bits = bits + 4'h1;
          if (bits == `DDS_BIT_LAST)
            next_state = DDS_TX_END;
          else
          begin
            next_shift = {shift[14:0], 1'b0};
            next_serial_in = shift[14];
            next_state = DDS_TX_HIGH;
          end
        end
      DDS_TX_END:
        if (div == 3'h0)
        begin
          next_fs_n  = 1'b1;
          next_ready = 1'b1;
          next_state = DDS_TX_IDLE;
        end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state     <= DDS_TX_IDLE;
      shift     <= 16'h0000;
      div       <= 3'h0;
      bits      <= 4'h0;
      init_done <= 1'b0;
      cmd_ready <= 1'b0;
      sclk_r    <= 1'b1;
      fs_n_r    <= 1'b1;
      serial_in_r   <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      shift     <= next_shift;
      div       <= next_div;
      bits      <= next_bits;
      init_done <= next_init_done;
      cmd_ready <= next_ready;
      sclk_r    <= next_sclk;
      fs_n_r    <= next_fs_n;
      serial_in_r   <= next_serial_in;
    end
  end

endmodule // dds_host

//--- design/dds_sine_lookup.sv
// Phase-to-amplitude conversion for the sinusoid output path.
// Assumes a 10-bit phase and offset-binary 10-bit amplitude; purely combinational.
`timescale 1ns/1ps
`include "dds_consts.svh"

module dds_sine_lookup
  import dds_pkg::*;
(
  // Phase in
  input  wire logic [9:0] phase,
  // Amplitude out
  output logic      [9:0] amplitude
);

  // ========================================================================
  // Half-wave shaping
  // ========================================================================
  // A parabola per half cycle; it trades a few percent harmonic error for
  // a table that would otherwise cost far more area than the datapath.
  function automatic logic [8:0] dds_half_wave(input logic [8:0] x);
    logic [17:0] prod;
    prod = 18'({9'h0, x} * (18'h200 - {9'h0, x}));
    dds_half_wave = (prod[17:7] > 11'h1FF) ? 9'h1FF : prod[15:7];
  endfunction

  // Lower half cycle (phase[9] low) adds to midscale, upper half subtracts.
  always_comb
  begin
    if (!phase[9])
      amplitude = `DDS_MIDSCALE + {1'b0, dds_half_wave(phase[8:0])};
    else
      amplitude = `DDS_MIDSCALE - {1'b0, dds_half_wave(phase[8:0])};
  end

endmodule // dds_sine_lookup

//--- dv/dds_link_props.sv
// Link checker: frame length, serial clock shape, data hold and bit count.
// Assumes the link wires are sampled on core_clk and driven by the host end.
`timescale 1ns/1ps

module dds_link_props
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Link wires
  input  wire logic sclk,
  input  wire logic frame_sync_n,
  input  wire logic serial_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ========================================================================
  // Helper: falling clock edges seen inside the present frame
  // ========================================================================
  logic [4:0] fall_count;
  logic [4:0] next_fall_count;
  logic       sclk_last;

  // The count clears between frames, so a short frame cannot hide in the next.
  always_comb
  begin
    next_fall_count = fall_count;
    if (frame_sync_n)
      next_fall_count = 5'h00;
    else if (sclk_last && !sclk)
      next_fall_count = fall_count + 5'h01;
  end

  // Registers only.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fall_count <= 5'h00;
      sclk_last  <= 1'b1;
    end
    else
    begin
      fall_count <= next_fall_count;
      sclk_last  <= sclk;
    end
  end

  // ========================================================================
  // Properties
  // ========================================================================
  property p_idle_high; frame_sync_n |-> sclk; endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("clock low outside frame");
  property p_setup; $fell(frame_sync_n) |-> sclk [*3] ##1 !sclk; endproperty
  a_setup: assert property (p_setup)
    else $error("bad frame setup");
  property p_low_half; $fell(sclk) |-> !sclk [*3] ##1 sclk; endproperty
  a_low_half: assert property (p_low_half)
    else $error("bad low half");
  property p_high_half; $rose(sclk) && !frame_sync_n |-> sclk [*3]; endproperty
  a_high_half: assert property (p_high_half)
    else $error("bad high half");
  property p_data_hold; !sclk |-> $stable(serial_in); endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data moved while clock low");
  property p_frame_len; $fell(frame_sync_n) |-> ##98 !frame_sync_n ##1 frame_sync_n; endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length wrong");
  property p_bit_count; $rose(frame_sync_n) |-> fall_count == 5'h10; endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("frame bit count wrong");
  // The clock must stay high for a full half period before the frame closes.
  property p_end_hold;
    $rose(frame_sync_n) |-> sclk && $past(sclk) && $past(sclk, 2) && $past(sclk, 3);
  endproperty
  a_end_hold: assert property (p_end_hold)
    else $error("frame end hold too short");
endmodule // dds_link_props

//--- dv/dds_word_decoder_and_output_select_tb.sv
// Testbench: host end feeds device end; the period, start_gap and span tasks judge the device outputs.
// Assumes package, interface, design and link checker are compiled first.
`timescale 1ns/1ps

module dds_word_decoder_and_output_select_tb
  import dds_pkg::*;
;
  logic         core_clk = 1'b0;
  logic         reset_n;
  logic         cmd_valid;
  dds_word_type cmd_word;
  logic         cmd_ready;
  logic   [9:0] dac_code;
  logic         dac_powered;
  logic         square_out;
  logic         core_running;
  int           num_errors = 0;
  int           samples_checked = 0;
  int           n0;
  int           n1;
  logic   [9:0] held;
  logic   [9:0] lo;
  logic   [9:0] hi;

  // ========================================================================
  // Both ends across one link, checker beside it
  // ========================================================================
  dds_link_if link ();
  dds_host u_dds_host (.core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .cmd_ready(cmd_ready), .link(link));
  dds_device u_dds_device (.core_clk(core_clk), .reset_n(reset_n), .link(link),
    .dac_code(dac_code), .dac_powered(dac_powered), .square_out(square_out),
    .core_running(core_running));
  dds_link_props u_dds_link_props (.core_clk(core_clk), .reset_n(reset_n),
    .sclk(link.sclk), .frame_sync_n(link.frame_sync_n), .serial_in(link.serial_in));

  // Clock of 5 ns period.
  always #2.5 core_clk = ~core_clk;

  // ========================================================================
  // Tasks
  // ========================================================================
  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic give_up();
    num_errors++;
    give_verdict();
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for the host to be idle.
  task automatic wait_ready();
    for (int n = 0; cmd_ready !== 1'b1; n++)
    begin
      if (n > 400) give_up();
      @(negedge core_clk);
    end
  endtask

  // One word per frame; returns once the frame is over.
  task automatic send(input dds_word_type w);
    wait_ready();
    cmd_word  = w;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    @(negedge core_clk);
    wait_ready();
  endtask

  task automatic wait_rise(output int n);
    logic last;
    last = square_out;
    for (n = 1; n < 1000; n++)
    begin
      @(negedge core_clk);
      if (last === 1'b0 && square_out === 1'b1) return;
      last = square_out;
    end
    give_up();
  endtask

  // Two rises: the first only aligns, the second gives the period.
  task automatic period(input logic [15:0] exp);
    int n;
    wait_rise(n);
    wait_rise(n);
    chk(16'(n), exp);
  endtask

  // Latency from the accumulator restart to the first square rise.
  task automatic start_gap(input dds_word_type c, output int n);
    send(c | 16'h0100);
    send(c);
    for (n = 0; core_running !== 1'b1; n++)
    begin
      if (n > 20) give_up();
      @(negedge core_clk);
    end
    chk(16'(n), 16'h0005);
    for (n = 0; square_out !== 1'b1; n++)
    begin
      if (n > 200) give_up();
      @(negedge core_clk);
    end
  endtask

  // A full cycle of the analog path must swing nearly end to end.
  task automatic span();
    lo = 10'h3FF;
    hi = 10'h000;
    repeat (64)
    begin
      @(negedge core_clk);
      if (dac_code < lo) lo = dac_code;
      if (dac_code > hi) hi = dac_code;
    end
    chk(16'(hi > 10'h300), 16'h0001);
    chk(16'(lo < 10'h100), 16'h0001);
  endtask

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial
  begin
    reset_n   = 1'b0;
    cmd_valid = 1'b0;
    cmd_word  = 16'h0000;
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    wait_ready();
    chk(16'(dac_code), 16'h0200);
    chk(16'(core_running), 16'h0000);
    send(16'h2100);
    send(16'h4000);
    send(16'h4100);
    send(16'h0100);
    send(16'h8000);
    send(16'h1100);
    send(16'h8200);
    send(16'h0028);
    chk(16'(core_running), 16'h0000);
    period(16'h0040);
    send(16'h0020);
    period(16'h0080);
    send(16'h0828);
    period(16'h0020);
    for (int i = 0; i < 4; i++)
    begin
      send(16'h0800 | 16'(i << 6));
      repeat (3) @(negedge core_clk);
      held = dac_code;
      repeat (10) @(negedge core_clk);
      chk(16'(dac_powered), 16'(!i[0]));
      chk(16'(core_running), 16'(!i[1]));
      if (i[1]) chk(16'(dac_code), 16'(held));
    end
    send(16'h00E8);
    send(16'h0028);
    period(16'h0040);
    send(16'h0042);
    chk(16'(dac_powered), 16'h0001);
    span();
    chk(16'(dac_code[0]), 16'h0000);
    send(16'h0000);
    span();
    send(16'h0022);
    repeat (3) @(negedge core_clk);
    chk(16'(dac_code), 16'h0200);
    chk(16'(square_out), 16'h0000);
    start_gap(16'h0028, n0);
    send(16'hD400);
    start_gap(16'h0028, n1);
    chk(16'(n0 - n1), 16'h0010);
    send(16'hE600);
    start_gap(16'h0428, n1);
    chk(16'(n0 - n1), 16'h0018);
    give_verdict();
  end
endmodule // dds_word_decoder_and_output_select_tb
